// ---- chpic_pkg.sv ----
// Shared constants and types of the host port and interrupt chain block
package chpic_pkg;

    localparam int DATA_W  = 8;
    localparam int PORTC_W = 4;
    localparam int ADDR_W  = 6;

    localparam logic [1:0] SEL_PORTA = 2'h0;
    localparam logic [1:0] SEL_PORTB = 2'h1;
    localparam logic [1:0] SEL_PORTC = 2'h2;
    localparam logic [1:0] SEL_CTRL  = 2'h3;

    // Internal register addresses
    localparam logic [ADDR_W-1:0] ADDR_MASTER  = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_A_CS    = 6'h01;
    localparam logic [ADDR_W-1:0] ADDR_B_CS    = 6'h02;
    localparam logic [ADDR_W-1:0] ADDR_VECTOR  = 6'h03;
    localparam logic [ADDR_W-1:0] ADDR_CUR_VEC = 6'h04;
    localparam logic [ADDR_W-1:0] ADDR_A_DIR   = 6'h08;
    localparam logic [ADDR_W-1:0] ADDR_A_POL   = 6'h09;
    localparam logic [ADDR_W-1:0] ADDR_A_OD    = 6'h0A;
    localparam logic [ADDR_W-1:0] ADDR_A_MASK  = 6'h0B;
    localparam logic [ADDR_W-1:0] ADDR_A_DATA  = 6'h0D;
    localparam logic [ADDR_W-1:0] ADDR_B_DATA  = 6'h0E;
    localparam logic [ADDR_W-1:0] ADDR_C_DATA  = 6'h0F;
    localparam logic [ADDR_W-1:0] ADDR_B_DIR   = 6'h10;
    localparam logic [ADDR_W-1:0] ADDR_B_POL   = 6'h11;
    localparam logic [ADDR_W-1:0] ADDR_B_OD    = 6'h12;
    localparam logic [ADDR_W-1:0] ADDR_B_MASK  = 6'h13;
    localparam logic [ADDR_W-1:0] ADDR_C_DIR   = 6'h18;
    localparam logic [ADDR_W-1:0] ADDR_C_POL   = 6'h19;
    localparam logic [ADDR_W-1:0] ADDR_C_OD    = 6'h1A;

    // Field positions
    localparam int MIC_MIE   = 7;
    localparam int CS_IUS    = 7;
    localparam int CS_IE     = 6;
    localparam int CS_IP     = 5;
    localparam int CS_ACTIVE = 0;

    // Reset values
    localparam logic [DATA_W-1:0] RST_ZERO  = 8'h00;
    localparam logic [DATA_W-1:0] RST_ONES  = 8'hFF;
    localparam logic [DATA_W-1:0] VEC_NONE  = 8'hFF;
    localparam logic [ADDR_W-1:0] RST_PTR   = 6'h00;

    typedef struct packed {
        logic              readN;
        logic              writeN;
        logic              chipEnableN;
        logic [1:0]        regSelect;
        logic [DATA_W-1:0] data;
    } chpic_host_s;

    localparam chpic_host_s HOST_IDLE = '{readN: 1'b1, writeN: 1'b1, chipEnableN: 1'b1,
                                          regSelect: SEL_PORTA, data: RST_ZERO};

    typedef enum logic {
        PTR_WAIT  = 1'b0,
        PTR_READY = 1'b1
    } chpic_ptr_e;

endpackage

// ---- chpic_port_bits.sv ----
// One parallel port: pin synchronisers, output, direction, polarity, open-drain
`timescale 1ns/10ps
`default_nettype none
module chpic_port_bits
    import chpic_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             softReset,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut,
    output logic      [WIDTH-1:0] pinOeN,
    input  wire logic [WIDTH-1:0] writeData,
    input  wire logic             writeOut,
    input  wire logic             writeDir,
    input  wire logic             writePol,
    input  wire logic             writeOd,
    output logic      [WIDTH-1:0] readValue,
    output logic      [WIDTH-1:0] inputs,
    output logic      [WIDTH-1:0] changed,
    output logic      [WIDTH-1:0] dir,
    output logic      [WIDTH-1:0] pol,
    output logic      [WIDTH-1:0] od
);
    logic [WIDTH-1:0] pinMeta_reg;
    logic [WIDTH-1:0] pinSync_reg;
    logic [WIDTH-1:0] pinPrev_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] drive;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta_reg <= '0;
            pinSync_reg <= '0;
            pinPrev_reg <= '0;
        end else begin
            pinMeta_reg <= pinIn;
            pinSync_reg <= pinMeta_reg;
            pinPrev_reg <= pinSync_reg;
        end
    end

    // Writes to input bits are dropped
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_reg <= '0;
            dir     <= '1;
            pol     <= '0;
            od      <= '0;
        end else if (softReset) begin
            out_reg <= '0;
            dir     <= '1;
            pol     <= '0;
            od      <= '0;
        end else begin
            if (writeOut) out_reg <= (out_reg & dir) | (writeData & ~dir);
            if (writeDir) dir <= writeData;
            if (writePol) pol <= writeData;
            if (writeOd)  od  <= writeData;
        end
    end

    assign drive = out_reg ^ pol;

    // Each line: input, push-pull output or open-drain output
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pinOut <= '0;
            pinOeN <= '1;
        end else begin
            pinOut <= drive;
            pinOeN <= dir | (od & drive);
        end
    end

    assign inputs    = (pinSync_reg ^ pol) & dir;
    assign changed   = (pinSync_reg ^ pinPrev_reg) & dir;
    assign readValue = inputs | (out_reg & ~dir);

endmodule
`default_nettype wire

// ---- chpic_irq_channel.sv ----
// Pending, under-service and enable flags of one interrupt source
`timescale 1ns/10ps
`default_nettype none
module chpic_irq_channel
    import chpic_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              softReset,
    input  wire logic              setEvent,
    input  wire logic              setService,
    input  wire logic              csWrite,
    input  wire logic [DATA_W-1:0] writeData,
    output logic                   pending,
    output logic                   service,
    output logic                   enable,
    output logic                   request
);
    // Hardware set wins over a clear written in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pending <= 1'b0;
            service <= 1'b0;
            enable  <= 1'b0;
        end else if (softReset) begin
            pending <= 1'b0;
            service <= 1'b0;
            enable  <= 1'b0;
        end else begin
            if (setEvent) pending <= 1'b1;
            else if (csWrite) pending <= writeData[CS_IP];
            if (setService) service <= 1'b1;
            else if (csWrite) service <= writeData[CS_IUS];
            if (csWrite) enable <= writeData[CS_IE];
        end
    end

    assign request = pending & enable & ~service;

endmodule
`default_nettype wire

// ---- chpic_host_port.sv ----
// Host data port, indirect control registers and interrupt daisy chain
`timescale 1ns/10ps
`default_nettype none
module chpic_host_port
    import chpic_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               reset_n,
    input  wire logic               readN,
    input  wire logic               writeN,
    input  wire logic               chipEnableN,
    input  wire logic [1:0]         regSelect,
    input  wire logic [DATA_W-1:0]  hostDataBusIn,
    output logic      [DATA_W-1:0]  hostDataBusOut,
    output logic                    hostDataBusOeN,
    input  wire logic               ackCycleN,
    input  wire logic               chainEnableIn,
    output logic                    chainEnableOut,
    output logic                    irqRequestNOut,
    output logic                    irqRequestNOeN,
    input  wire logic [DATA_W-1:0]  firstPortLinesIn,
    output logic      [DATA_W-1:0]  firstPortLinesOut,
    output logic      [DATA_W-1:0]  firstPortLinesOeN,
    input  wire logic [DATA_W-1:0]  secondPortLinesIn,
    output logic      [DATA_W-1:0]  secondPortLinesOut,
    output logic      [DATA_W-1:0]  secondPortLinesOeN,
    input  wire logic [PORTC_W-1:0] thirdPortLinesIn,
    output logic      [PORTC_W-1:0] thirdPortLinesOut,
    output logic      [PORTC_W-1:0] thirdPortLinesOeN
);
    chpic_host_s       hostRaw;
    chpic_host_s       hostMeta_reg;
    chpic_host_s       hostSync_reg;
    chpic_host_s       hostPrev_reg;
    logic              chainMeta_reg;
    logic              chainSync_reg;
    chpic_ptr_e        ptrState_reg;
    logic [ADDR_W-1:0] ptr_reg;
    logic              mie_reg;
    logic [DATA_W-1:0] vecBase_reg;
    logic [DATA_W-1:0] maskA_reg;
    logic [DATA_W-1:0] maskB_reg;

    logic              softReset;
    logic              selected;
    logic              writeStart;
    logic              readStart;
    logic              ackRead;
    logic              ctrlSel;
    logic              ptrLoad;
    logic              ctrlWrite;
    logic [ADDR_W-1:0] accAddr;
    logic [DATA_W-1:0] wData;
    logic              regWrite;
    logic [DATA_W-1:0] readValue;
    logic [DATA_W-1:0] currentVector;
    logic              grant;

    logic [DATA_W-1:0]  aValue, aIn, aChg, aDir, aPol, aOd;
    logic [DATA_W-1:0]  bValue, bIn, bChg, bDir, bPol, bOd;
    logic [PORTC_W-1:0] cValue, cDir, cPol, cOd;
    logic               ipA, iusA, ieA, reqA;
    logic               ipB, iusB, ieB, reqB;
    logic               reqAny;
    logic               anyService;
    logic [DATA_W-1:0]  csA, csB;

    // Host strobes, select and data are asynchronous to the clock
    assign hostRaw = {readN, writeN, chipEnableN, regSelect, hostDataBusIn};

    // The whole host side runs from this clock, so it must keep running
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hostMeta_reg <= HOST_IDLE;
            hostSync_reg <= HOST_IDLE;
            hostPrev_reg <= HOST_IDLE;
        end else begin
            hostMeta_reg <= hostRaw;
            hostSync_reg <= hostMeta_reg;
            hostPrev_reg <= hostSync_reg;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            chainMeta_reg <= 1'b0;
            chainSync_reg <= 1'b0;
        end else begin
            chainMeta_reg <= chainEnableIn;
            chainSync_reg <= chainMeta_reg;
        end
    end

    assign softReset = ~hostSync_reg.readN & ~hostSync_reg.writeN;
    assign selected  = ~hostSync_reg.chipEnableN;
    // Acknowledge input is already on this clock and is used without a synchroniser
    assign writeStart = selected & ackCycleN & hostSync_reg.readN
                      & hostPrev_reg.writeN & ~hostSync_reg.writeN;
    assign readStart  = selected & ackCycleN & hostSync_reg.writeN
                      & hostPrev_reg.readN & ~hostSync_reg.readN;
    assign ackRead    = ~ackCycleN & hostSync_reg.writeN
                      & hostPrev_reg.readN & ~hostSync_reg.readN;

    assign ctrlSel   = hostSync_reg.regSelect == SEL_CTRL;
    assign ptrLoad   = writeStart & ctrlSel & (ptrState_reg == PTR_WAIT);
    assign ctrlWrite = writeStart & ctrlSel & (ptrState_reg == PTR_READY);
    assign wData     = hostSync_reg.data;

    // Data registers map directly, anything else goes through the pointer
    always_comb begin
        unique case (hostSync_reg.regSelect)
            SEL_PORTA: accAddr = ADDR_A_DATA;
            SEL_PORTB: accAddr = ADDR_B_DATA;
            SEL_PORTC: accAddr = ADDR_C_DATA;
            SEL_CTRL:  accAddr = ptr_reg;
        endcase
    end

    assign regWrite = (writeStart & ~ctrlSel) | ctrlWrite;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ptrState_reg <= PTR_WAIT;
            ptr_reg      <= RST_PTR;
        end else if (softReset) begin
            ptrState_reg <= PTR_WAIT;
            ptr_reg      <= RST_PTR;
        end else begin
            unique case (ptrState_reg)
                PTR_WAIT: begin
                    if (ptrLoad) begin
                        ptr_reg      <= wData[ADDR_W-1:0];
                        ptrState_reg <= PTR_READY;
                    end
                end
                PTR_READY: begin
                    if (ctrlWrite || (readStart && ctrlSel)) begin
                        ptrState_reg <= PTR_WAIT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mie_reg     <= 1'b0;
            vecBase_reg <= RST_ZERO;
            maskA_reg   <= RST_ZERO;
            maskB_reg   <= RST_ZERO;
        end else if (softReset) begin
            mie_reg     <= 1'b0;
            vecBase_reg <= RST_ZERO;
            maskA_reg   <= RST_ZERO;
            maskB_reg   <= RST_ZERO;
        end else if (regWrite) begin
            if (accAddr == ADDR_MASTER) mie_reg <= wData[MIC_MIE];
            if (accAddr == ADDR_VECTOR) vecBase_reg <= wData;
            if (accAddr == ADDR_A_MASK) maskA_reg <= wData;
            if (accAddr == ADDR_B_MASK) maskB_reg <= wData;
        end
    end

    chpic_port_bits #(.WIDTH(DATA_W)) firstPort (
        .clock     (clock),
        .reset_n   (reset_n),
        .softReset (softReset),
        .pinIn     (firstPortLinesIn),
        .pinOut    (firstPortLinesOut),
        .pinOeN    (firstPortLinesOeN),
        .writeData (wData),
        .writeOut  (regWrite && accAddr == ADDR_A_DATA),
        .writeDir  (regWrite && accAddr == ADDR_A_DIR),
        .writePol  (regWrite && accAddr == ADDR_A_POL),
        .writeOd   (regWrite && accAddr == ADDR_A_OD),
        .readValue (aValue),
        .inputs    (aIn),
        .changed   (aChg),
        .dir       (aDir),
        .pol       (aPol),
        .od        (aOd)
    );

    chpic_port_bits #(.WIDTH(DATA_W)) secondPort (
        .clock     (clock),
        .reset_n   (reset_n),
        .softReset (softReset),
        .pinIn     (secondPortLinesIn),
        .pinOut    (secondPortLinesOut),
        .pinOeN    (secondPortLinesOeN),
        .writeData (wData),
        .writeOut  (regWrite && accAddr == ADDR_B_DATA),
        .writeDir  (regWrite && accAddr == ADDR_B_DIR),
        .writePol  (regWrite && accAddr == ADDR_B_POL),
        .writeOd   (regWrite && accAddr == ADDR_B_OD),
        .readValue (bValue),
        .inputs    (bIn),
        .changed   (bChg),
        .dir       (bDir),
        .pol       (bPol),
        .od        (bOd)
    );

    chpic_port_bits #(.WIDTH(PORTC_W)) thirdPort (
        .clock     (clock),
        .reset_n   (reset_n),
        .softReset (softReset),
        .pinIn     (thirdPortLinesIn),
        .pinOut    (thirdPortLinesOut),
        .pinOeN    (thirdPortLinesOeN),
        .writeData (wData[PORTC_W-1:0]),
        .writeOut  (regWrite && accAddr == ADDR_C_DATA),
        .writeDir  (regWrite && accAddr == ADDR_C_DIR),
        .writePol  (regWrite && accAddr == ADDR_C_POL),
        .writeOd   (regWrite && accAddr == ADDR_C_OD),
        .readValue (cValue),
        .inputs    (),
        .changed   (),
        .dir       (cDir),
        .pol       (cPol),
        .od        (cOd)
    );

    // Priority inside the device: first port above second port
    assign grant = ackRead & chainSync_reg & reqAny & ~anyService;

    chpic_irq_channel irqA (
        .clock      (clock),
        .reset_n    (reset_n),
        .softReset  (softReset),
        .setEvent   (|(aChg & maskA_reg)),
        .setService (grant & reqA),
        .csWrite    (regWrite && accAddr == ADDR_A_CS),
        .writeData  (wData),
        .pending    (ipA),
        .service    (iusA),
        .enable     (ieA),
        .request    (reqA)
    );

    chpic_irq_channel irqB (
        .clock      (clock),
        .reset_n    (reset_n),
        .softReset  (softReset),
        .setEvent   (|(bChg & maskB_reg)),
        .setService (grant & ~reqA & reqB),
        .csWrite    (regWrite && accAddr == ADDR_B_CS),
        .writeData  (wData),
        .pending    (ipB),
        .service    (iusB),
        .enable     (ieB),
        .request    (reqB)
    );

    assign reqAny     = mie_reg & (reqA | reqB);
    assign anyService = iusA | iusB;

    always_comb begin
        if (reqA) begin
            currentVector = {vecBase_reg[DATA_W-1:1], 1'b0};
        end else if (reqB) begin
            currentVector = {vecBase_reg[DATA_W-1:1], 1'b1};
        end else begin
            currentVector = VEC_NONE;
        end
    end

    // Status bit is live; a write to its position is not stored
    always_comb begin
        csA = RST_ZERO;
        csA[CS_IUS]    = iusA;
        csA[CS_IE]     = ieA;
        csA[CS_IP]     = ipA;
        csA[CS_ACTIVE] = |(aIn & maskA_reg);
        csB = RST_ZERO;
        csB[CS_IUS]    = iusB;
        csB[CS_IE]     = ieB;
        csB[CS_IP]     = ipB;
        csB[CS_ACTIVE] = |(bIn & maskB_reg);
    end

    always_comb begin
        readValue = RST_ZERO;
        unique case (accAddr)
            ADDR_MASTER:  readValue[MIC_MIE] = mie_reg;
            ADDR_A_CS:    readValue = csA;
            ADDR_B_CS:    readValue = csB;
            ADDR_VECTOR:  readValue = vecBase_reg;
            ADDR_CUR_VEC: readValue = currentVector;
            ADDR_A_DIR:   readValue = aDir;
            ADDR_A_POL:   readValue = aPol;
            ADDR_A_OD:    readValue = aOd;
            ADDR_A_MASK:  readValue = maskA_reg;
            ADDR_A_DATA:  readValue = aValue;
            ADDR_B_DATA:  readValue = bValue;
            ADDR_C_DATA:  readValue = {{(DATA_W-PORTC_W){1'b0}}, cValue};
            ADDR_B_DIR:   readValue = bDir;
            ADDR_B_POL:   readValue = bPol;
            ADDR_B_OD:    readValue = bOd;
            ADDR_B_MASK:  readValue = maskB_reg;
            ADDR_C_DIR:   readValue = {{(DATA_W-PORTC_W){1'b0}}, cDir};
            ADDR_C_POL:   readValue = {{(DATA_W-PORTC_W){1'b0}}, cPol};
            ADDR_C_OD:    readValue = {{(DATA_W-PORTC_W){1'b0}}, cOd};
            default:      readValue = RST_ZERO;
        endcase
    end

    // Bus is driven only for a register read or a granted vector
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hostDataBusOut <= RST_ZERO;
            hostDataBusOeN <= 1'b1;
        end else if (softReset) begin
            hostDataBusOeN <= 1'b1;
        end else if (readStart) begin
            hostDataBusOut <= readValue;
            hostDataBusOeN <= 1'b0;
        end else if (grant) begin
            hostDataBusOut <= currentVector;
            hostDataBusOeN <= 1'b0;
        end else if (hostSync_reg.readN || (ackCycleN && !selected)) begin
            hostDataBusOeN <= 1'b1;
        end
    end

    // Outside acknowledge a served request still blocks lower devices
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            chainEnableOut <= 1'b0;
            irqRequestNOeN <= 1'b1;
        end else begin
            if (!ackCycleN) begin
                chainEnableOut <= chainSync_reg & ~reqAny & ~anyService;
            end else begin
                chainEnableOut <= chainSync_reg & ~anyService;
            end
            irqRequestNOeN <= ~(reqAny & ~anyService);
        end
    end

    // Open-drain: the line is only ever pulled low
    assign irqRequestNOut = 1'b0;

endmodule
`default_nettype wire

// ---- chpic_host_port_chk.sv ----
// Port-level assertions for the host port and interrupt chain
`timescale 1ns/10ps
`default_nettype none
module chpic_host_port_chk
    import chpic_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic readN,
    input wire logic writeN,
    input wire logic chipEnableN,
    input wire logic ackCycleN,
    input wire logic chainEnableIn,
    input wire logic chainEnableOut,
    input wire logic hostDataBusOeN,
    input wire logic irqRequestNOut,
    input wire logic irqRequestNOeN
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    bus_read_a: assert property (!hostDataBusOeN |-> !$past(readN, 3))
        else $error("bus driven without read");
    bus_ce_a: assert property (
        (!hostDataBusOeN && ackCycleN) |-> !$past(chipEnableN, 3))
        else $error("bus driven while not enabled");
    bus_release_a: assert property (readN [*4] |-> hostDataBusOeN)
        else $error("bus held after read");
    soft_reset_a: assert property (
        (!readN && !writeN) [*6] |-> hostDataBusOeN && irqRequestNOeN)
        else $error("strobe reset did not clear");
    irq_level_a: assert property (irqRequestNOut == 1'b0)
        else $error("interrupt line value not low");
    chain_ack_a: assert property ((!ackCycleN && !irqRequestNOeN) |=> !chainEnableOut)
        else $error("chain out high while requesting");
    vector_chain_a: assert property (
        (!ackCycleN && $fell(hostDataBusOeN)) |-> $past(chainEnableIn, 3))
        else $error("vector without chain enable");
    vector_serve_a: assert property (
        (!ackCycleN && $fell(hostDataBusOeN)) |-> ##[0:1] irqRequestNOeN)
        else $error("request kept after vector");
    cover property ($fell(hostDataBusOeN) && ackCycleN);
    cover property (!ackCycleN && $fell(hostDataBusOeN));
    cover property ($fell(irqRequestNOeN));
endmodule
`default_nettype wire

// ---- chpic_pins.sv ----
// Far-side port equipment driving the lines the block lets go
`timescale 1ns/10ps
`default_nettype none
module chpic_pins #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pinOut,
    input  wire logic [W-1:0] pinOeN,
    input  wire logic [W-1:0] extDrive,
    output logic      [W-1:0] pinLevel
);
    // Block drives enabled bits, equipment the rest
    assign pinLevel = (pinOut & ~pinOeN) | (extDrive & pinOeN);
endmodule
`default_nettype wire

// ---- chpic_host_port_tb.sv ----
// Self-checking bench of the host port and interrupt chain
`timescale 1ns/10ps
`default_nettype none
module chpic_host_port_tb;
    import chpic_pkg::*;
    logic clock, reset_n, readN, writeN, chipEnableN, ackCycleN, chainEnableIn, gotOe;
    logic busOeN, chainOut, irqOut, irqOeN;
    logic [1:0] regSelect, sel;
    logic [DATA_W-1:0] dataIn, dataOut, extA, extB, pinA, pinB, outA, outB, oeA, oeB, got, v, w;
    logic [PORTC_W-1:0] extC, pinC, outC, oeC;
    int miscompares, n_tests, cycles, seed, i;
    chpic_host_port chpic_host_port_inst (.clock(clock), .reset_n(reset_n), .readN(readN),
        .writeN(writeN), .chipEnableN(chipEnableN), .regSelect(regSelect),
        .hostDataBusIn(dataIn), .hostDataBusOut(dataOut), .hostDataBusOeN(busOeN),
        .ackCycleN(ackCycleN), .chainEnableIn(chainEnableIn), .chainEnableOut(chainOut),
        .irqRequestNOut(irqOut), .irqRequestNOeN(irqOeN), .firstPortLinesIn(pinA),
        .firstPortLinesOut(outA), .firstPortLinesOeN(oeA), .secondPortLinesIn(pinB),
        .secondPortLinesOut(outB), .secondPortLinesOeN(oeB), .thirdPortLinesIn(pinC),
        .thirdPortLinesOut(outC), .thirdPortLinesOeN(oeC));
    chpic_pins #(.W(8)) chpic_pins_a_inst (.pinOut(outA), .pinOeN(oeA),
        .extDrive(extA), .pinLevel(pinA));
    chpic_pins #(.W(8)) chpic_pins_b_inst (.pinOut(outB), .pinOeN(oeB),
        .extDrive(extB), .pinLevel(pinB));
    chpic_pins #(.W(4)) chpic_pins_c_inst (.pinOut(outC), .pinOeN(oeC),
        .extDrive(extC), .pinLevel(pinC));
    function automatic logic [DATA_W-1:0] portMask(input logic [1:0] s);
        return (s == SEL_PORTC) ? 8'h0F : 8'hFF;
    endfunction
    task automatic check(input string what, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic access(input logic rd, input logic ce, input logic [1:0] s,
                          input logic [7:0] d);
        @(posedge clock);
        chipEnableN <= ce;
        regSelect <= s;
        dataIn <= d;
        if (rd) readN <= 1'b0;
        else writeN <= 1'b0;
        repeat (4) @(posedge clock);
        #1 got = dataOut;
        gotOe = busOeN;
        @(posedge clock);
        readN <= 1'b1;
        writeN <= 1'b1;
        chipEnableN <= 1'b1;
        dataIn <= ~d;
        repeat (4) @(posedge clock);
    endtask
    task automatic creg_w(input logic [5:0] a, input logic [7:0] d);
        access(1'b0, 1'b0, SEL_CTRL, {2'h0, a});
        access(1'b0, 1'b0, SEL_CTRL, d);
    endtask
    task automatic creg_r(input logic [5:0] a);
        access(1'b0, 1'b0, SEL_CTRL, {2'h0, a});
        access(1'b1, 1'b0, SEL_CTRL, RST_ZERO);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clock);
            cycles++;
            if (cycles == 20000) begin
                miscompares++;
                close_out();
            end
        end
    end
    initial begin
        seed = 61741;
        {reset_n, readN, writeN, chipEnableN, ackCycleN, chainEnableIn} = 6'h1F;
        regSelect = SEL_PORTA;
        {dataIn, extA, extB, extC} = 28'h0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        #1 check("port A enables", oeA, RST_ONES);
        check("bus enable", {7'h0, busOeN}, 8'h01);
        creg_w(ADDR_CUR_VEC, RST_ZERO);
        creg_r(ADDR_CUR_VEC);
        check("current vector", got, VEC_NONE);
        for (i = 0; i < 24; i++) begin
            v = 8'($random(seed));
            w = 8'($random(seed));
            sel = 2'(i % 3);
            creg_w(ADDR_A_DIR + 6'(8 * sel), RST_ZERO);
            access(1'b0, 1'b0, sel, v);
            access(1'b1, 1'b0, sel, RST_ZERO);
            check("port data", got & portMask(sel), v & portMask(sel));
            check("read enable", {7'h0, gotOe}, RST_ZERO);
            got = (sel == SEL_PORTA) ? pinA : (sel == SEL_PORTB) ? pinB : {4'h0, pinC};
            check("port lines", got, v & portMask(sel));
            creg_r(ADDR_A_DATA + 6'(sel));
            check("indirect data", got & portMask(sel), v & portMask(sel));
            creg_w(ADDR_A_DIR + 6'(8 * sel), RST_ONES);
            extA <= w;
            extB <= w;
            extC <= w[3:0];
            access(1'b1, 1'b0, sel, RST_ZERO);
            check("input read", got & portMask(sel), w & portMask(sel));
        end
        creg_w(ADDR_A_MASK, 8'h01);
        access(1'b0, 1'b1, SEL_CTRL, {2'h0, ADDR_A_DIR});
        creg_r(ADDR_A_MASK);
        check("mask after disabled write", got, 8'h01);
        creg_w(ADDR_VECTOR, 8'h5A);
        creg_w(ADDR_A_CS, 8'h40);
        creg_w(ADDR_MASTER, 8'h80);
        extA <= extA ^ 8'h01;
        repeat (8) @(posedge clock);
        #1 check("request", {7'h0, irqOeN}, RST_ZERO);
        check("chain idle", {7'h0, chainOut}, 8'h01);
        @(posedge clock);
        ackCycleN <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check("chain in ack", {7'h0, chainOut}, RST_ZERO);
        access(1'b1, 1'b0, SEL_PORTA, RST_ZERO);
        check("vector", got, 8'h5A);
        check("request served", {7'h0, irqOeN}, 8'h01);
        ackCycleN <= 1'b1;
        creg_w(ADDR_A_CS, 8'h40);
        chainEnableIn <= 1'b0;
        extA <= extA ^ 8'h01;
        repeat (8) @(posedge clock);
        ackCycleN <= 1'b0;
        access(1'b1, 1'b0, SEL_PORTA, RST_ZERO);
        check("vector refused", {7'h0, gotOe}, 8'h01);
        ackCycleN <= 1'b1;
        chainEnableIn <= 1'b1;
        readN <= 1'b0;
        writeN <= 1'b0;
        repeat (6) @(posedge clock);
        readN <= 1'b1;
        writeN <= 1'b1;
        repeat (4) @(posedge clock);
        #1 check("request after strobe reset", {7'h0, irqOeN}, 8'h01);
        creg_r(ADDR_A_MASK);
        check("mask after strobe reset", got, RST_ZERO);
        close_out();
    end
endmodule
bind chpic_host_port chpic_host_port_chk chk_inst (.clock(clock), .reset_n(reset_n),
    .readN(readN), .writeN(writeN), .chipEnableN(chipEnableN), .ackCycleN(ackCycleN),
    .chainEnableIn(chainEnableIn), .chainEnableOut(chainEnableOut),
    .hostDataBusOeN(hostDataBusOeN), .irqRequestNOut(irqRequestNOut),
    .irqRequestNOeN(irqRequestNOeN));
`default_nettype wire
